// ### pscg_pkg.sv
// Package with register map, field layout and reset values for the peripheral sleep clock gating block.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
// Summary of operation
// - Status reads raw or masked view, chosen by a control bit
// - Three status bits: oscillator power-up, synthesizer lock, brown-out
// - Regulator level field, eleven steps, resets to the middle setting
// - Regulator level read returns the held setting, not a measurement
// - Gating select clear: sleep and deep-sleep clocks follow run enables
// - Gating select set: sleep clocks follow per-peripheral sleep and deep-sleep bits
// - Gated deep-sleep with enable clear stops that peripheral clock
// - Leaving deep-sleep restarts run-enabled clocks; peripheral state kept
// - Deep-sleep bits are kept while gating is off but have no effect
// - Peripheral with run enable clear gets no clock and no access
// - Run, sleep and deep-sleep bits for twenty-six peripherals
// - Masked status and interrupt only for enabled events
// - Run enables clear at reset; usable five cycles after enable, fault before
// - Software clears an event by writing one; bit then deasserts
package pscg_pkg;
    localparam int PSCG_NPER = 26;
    localparam int PSCG_NEVT = 3;
    localparam logic [7:0] PSCG_RAW_OFS = 8'h00;
    localparam logic [7:0] PSCG_MASK_OFS = 8'h04;
    localparam logic [7:0] PSCG_CLR_OFS = 8'h08;
    localparam logic [7:0] PSCG_STAT_OFS = 8'h0c;
    localparam logic [7:0] PSCG_LEVEL_OFS = 8'h10;
    localparam logic [7:0] PSCG_CTRL_OFS = 8'h14;
    localparam logic [7:0] PSCG_RUN_OFS = 8'h18;
    localparam logic [7:0] PSCG_SLEEP_OFS = 8'h1c;
    localparam logic [7:0] PSCG_DEEP_OFS = 8'h20;
    localparam logic [7:0] PSCG_READY_OFS = 8'h24;
    localparam int PSCG_EVT_OSC_BIT = 0;
    localparam int PSCG_EVT_LOCK_BIT = 1;
    localparam int PSCG_EVT_BROWN_BIT = 2;
    localparam int PSCG_CTRL_GATE_BIT = 0;
    localparam int PSCG_CTRL_VIEW_BIT = 1;
    // Level codes 0..10 map to 2.25 V .. 2.75 V in 0.05 V steps
    localparam logic [3:0] PSCG_LEVEL_DEFAULT = 4'h5;
    localparam logic [3:0] PSCG_LEVEL_MAX = 4'ha;
    localparam logic [2:0] PSCG_ENABLE_DELAY_CNT = 3'h5;
endpackage : pscg_pkg

// ### pscg_sync2.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input comes from outside the clock domain.
`timescale 1ns/100ps
module pscg_sync2 (
    input wire logic clock,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta;
    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : pscg_sync2

// ### pscg_periph_slot.sv
// One peripheral slot: clock enable and the five-cycle enable settle counter.
// Assumes run, sleep and deep-sleep enables come from registers on the same clock.
`timescale 1ns/100ps
module pscg_periph_slot
    import pscg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic run_en,
    input wire logic sleep_en,
    input wire logic deep_en,
    input wire logic gating,
    input wire logic in_sleep,
    input wire logic in_deep,
    input wire logic access,
    output logic clk_en,
    output logic ready,
    output logic fault
);
    logic [2:0] settle;
    logic next_clk_en;

    always_ff @(posedge clock) begin
        if (rst) begin
            settle <= 3'h0;
        end else if (!run_en) begin
            settle <= 3'h0;
        end else if (settle != PSCG_ENABLE_DELAY_CNT) begin
            settle <= settle + 3'h1;
        end
    end

    assign ready = run_en && (settle == PSCG_ENABLE_DELAY_CNT);
    // Any access before ready is a bus fault to the requester
    assign fault = access && !ready;

    always_comb begin
        next_clk_en = run_en;
        if (gating && in_deep) begin
            next_clk_en = run_en && deep_en;
        end else if (gating && in_sleep) begin
            next_clk_en = run_en && sleep_en;
        end
    end

    // Registered enable keeps glitches off the clock gate
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_en <= 1'b0;
        end else begin
            clk_en <= next_clk_en;
        end
    end
endmodule : pscg_periph_slot

// ### pscg_top.sv
// Peripheral sleep clock gating top: Wishbone registers, events, interrupt, gating.
// Assumes processor sleep flags and event inputs may be asynchronous.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module pscg_top
    import pscg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic main_osc_powerup_event,
    input wire logic freq_synth_locked_event,
    input wire logic brownout_event,
    input wire logic proc_sleep,
    input wire logic proc_deep_sleep,
    input wire logic [PSCG_NPER-1:0] periph_access,
    output logic [PSCG_NPER-1:0] periph_clk_en,
    output logic [PSCG_NPER-1:0] periph_ready,
    output logic [PSCG_NPER-1:0] periph_fault,
    output logic [3:0] regulator_level,
    output logic irq
);
    logic [PSCG_NEVT-1:0] evt_async;
    logic [PSCG_NEVT-1:0] evt_sync;
    logic [PSCG_NEVT-1:0] evt_prev;
    logic [PSCG_NEVT-1:0] evt_pulse;
    logic [PSCG_NEVT-1:0] raw;
    logic [PSCG_NEVT-1:0] mask;
    logic [PSCG_NEVT-1:0] masked;
    logic [PSCG_NEVT-1:0] clr;
    logic sleep_s;
    logic deep_s;
    logic sleep_gating_select;
    logic masked_view_select;
    logic [PSCG_NPER-1:0] run_en;
    logic [PSCG_NPER-1:0] sleep_en;
    logic [PSCG_NPER-1:0] deep_en;
    logic req;
    logic wr;
    logic [31:0] next_dat;

    assign evt_async[PSCG_EVT_OSC_BIT] = main_osc_powerup_event;
    assign evt_async[PSCG_EVT_LOCK_BIT] = freq_synth_locked_event;
    assign evt_async[PSCG_EVT_BROWN_BIT] = brownout_event;

    genvar g;
    generate
        for (g = 0; g < PSCG_NEVT; g++) begin : g_evt
            pscg_sync2 u_sync (
                .clock(clock),
                .rst(rst),
                .din(evt_async[g]),
                .dout(evt_sync[g])
            );
        end
        // One slot per peripheral, each with its own enables
        for (g = 0; g < PSCG_NPER; g++) begin : g_per
            pscg_periph_slot u_slot (
                .clock(clock),
                .rst(rst),
                .run_en(run_en[g]),
                .sleep_en(sleep_en[g]),
                .deep_en(deep_en[g]),
                .gating(sleep_gating_select),
                .in_sleep(sleep_s),
                .in_deep(deep_s),
                .access(periph_access[g]),
                .clk_en(periph_clk_en[g]),
                .ready(periph_ready[g]),
                .fault(periph_fault[g])
            );
        end
    endgenerate

    pscg_sync2 u_sleep_sync (
        .clock(clock),
        .rst(rst),
        .din(proc_sleep),
        .dout(sleep_s)
    );

    pscg_sync2 u_deep_sync (
        .clock(clock),
        .rst(rst),
        .din(proc_deep_sleep),
        .dout(deep_s)
    );

    // Events are edges so a held level does not refire after clear
    always_ff @(posedge clock) begin
        if (rst) begin
            evt_prev <= '0;
        end else begin
            evt_prev <= evt_sync;
        end
    end
    assign evt_pulse = evt_sync & ~evt_prev;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign clr = (wr && wb_adr_i == PSCG_CLR_OFS && wb_sel_i[0]) ? wb_dat_i[PSCG_NEVT-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            raw <= '0;
        end else begin
            raw <= (raw & ~clr) | evt_pulse;
        end
    end

    assign masked = raw & mask;
    assign irq = |masked;

    always_ff @(posedge clock) begin
        if (rst) begin
            mask <= '0;
        end else if (wr && wb_adr_i == PSCG_MASK_OFS && wb_sel_i[0]) begin
            mask <= wb_dat_i[PSCG_NEVT-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sleep_gating_select <= 1'b0;
            masked_view_select <= 1'b0;
        end else if (wr && wb_adr_i == PSCG_CTRL_OFS && wb_sel_i[0]) begin
            sleep_gating_select <= wb_dat_i[PSCG_CTRL_GATE_BIT];
            masked_view_select <= wb_dat_i[PSCG_CTRL_VIEW_BIT];
        end
    end

    // Out-of-range level codes are ignored, setting kept
    always_ff @(posedge clock) begin
        if (rst) begin
            regulator_level <= PSCG_LEVEL_DEFAULT;
        end else if (wr && wb_adr_i == PSCG_LEVEL_OFS && wb_sel_i[0]
                     && wb_dat_i[3:0] <= PSCG_LEVEL_MAX) begin
            regulator_level <= wb_dat_i[3:0];
        end
    end

    function automatic logic [PSCG_NPER-1:0] pscg_merge(
        input logic [PSCG_NPER-1:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = {6'h00, old};
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res[PSCG_NPER-1:0];
    endfunction : pscg_merge

    always_ff @(posedge clock) begin
        if (rst) begin
            run_en <= '0;
        end else if (wr && wb_adr_i == PSCG_RUN_OFS) begin
            run_en <= pscg_merge(run_en, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sleep_en <= '0;
        end else if (wr && wb_adr_i == PSCG_SLEEP_OFS) begin
            sleep_en <= pscg_merge(sleep_en, wb_dat_i, wb_sel_i);
        end
    end

    // Stored regardless of gating select
    always_ff @(posedge clock) begin
        if (rst) begin
            deep_en <= '0;
        end else if (wr && wb_adr_i == PSCG_DEEP_OFS) begin
            deep_en <= pscg_merge(deep_en, wb_dat_i, wb_sel_i);
        end
    end

    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            PSCG_RAW_OFS: next_dat[PSCG_NEVT-1:0] = raw;
            PSCG_MASK_OFS: next_dat[PSCG_NEVT-1:0] = mask;
            PSCG_STAT_OFS: next_dat[PSCG_NEVT-1:0] = masked_view_select ? masked : raw;
            PSCG_LEVEL_OFS: next_dat[3:0] = regulator_level;
            PSCG_CTRL_OFS: begin
                next_dat[PSCG_CTRL_GATE_BIT] = sleep_gating_select;
                next_dat[PSCG_CTRL_VIEW_BIT] = masked_view_select;
            end
            PSCG_RUN_OFS: next_dat[PSCG_NPER-1:0] = run_en;
            PSCG_SLEEP_OFS: next_dat[PSCG_NPER-1:0] = sleep_en;
            PSCG_DEEP_OFS: next_dat[PSCG_NPER-1:0] = deep_en;
            PSCG_READY_OFS: next_dat[PSCG_NPER-1:0] = periph_ready;
            default: next_dat = 32'h0000_0000;
        endcase
    end

    // One-cycle ack; unmapped addresses ack with zero data
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= next_dat;
            end
        end
    end
endmodule : pscg_top

// ### pscg_props.sv
// Checker for the gating block top ports.
// Assumes the bind in the bench top file.
`timescale 1ns/100ps
module pscg_props
    import pscg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic proc_sleep,
    input wire logic proc_deep_sleep,
    input wire logic [PSCG_NPER-1:0] periph_access,
    input wire logic [PSCG_NPER-1:0] periph_clk_en,
    input wire logic [PSCG_NPER-1:0] periph_ready,
    input wire logic [PSCG_NPER-1:0] periph_fault,
    input wire logic [3:0] regulator_level,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    fault_view_a: assert property (periph_fault == (periph_access & ~periph_ready))
        else $error("fault does not match access and ready");
    reset_state_a: assert property ($fell(rst) |-> !irq && periph_ready == '0 && periph_clk_en == '0)
        else $error("outputs wrong after reset");
    level_reset_a: assert property ($fell(rst) |-> regulator_level == PSCG_LEVEL_DEFAULT)
        else $error("level wrong after reset");
    level_range_a: assert property (regulator_level <= PSCG_LEVEL_MAX)
        else $error("level out of range");
    // Settle count is exact; a lazy counter shows here first
    ready_delay_a: assert property ($rose(periph_ready[0]) |-> $past(wb_ack_o, 5))
        else $error("ready not five cycles after enable");
    clk_follow_a: assert property ((!proc_sleep && !proc_deep_sleep)[*4]
        |-> (periph_clk_en & periph_ready) == periph_ready)
        else $error("ready peripheral without clock while awake");
    cover property ($rose(irq));
    cover property ($rose(periph_ready[0]));
    cover property (proc_deep_sleep && periph_clk_en[0]);
endmodule : pscg_props

// ### pscg_core_model.sv
// Core side model: sleep state lines and peripheral access attempts.
// Assumes bench modes 0 run, 1 sleep, 2 deep-sleep.
`timescale 1ns/100ps
module pscg_core_model
    import pscg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic [PSCG_NPER-1:0] touch,
    output logic proc_sleep,
    output logic proc_deep_sleep,
    output logic [PSCG_NPER-1:0] periph_access
);
    always_ff @(posedge clock) begin
        proc_sleep <= !rst && mode == 2'h1;
        proc_deep_sleep <= !rst && mode == 2'h2;
    end
    // A sleeping core issues no loads
    always_ff @(posedge clock) begin
        periph_access <= (rst || mode != 2'h0) ? '0 : touch;
    end
endmodule : pscg_core_model

// ### tb.sv
// Bench top for the gating block.
// Assumes the core model drives sleep lines and accesses.
`timescale 1ns/100ps
module tb;
    import pscg_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq, proc_sleep, proc_deep_sleep;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic [2:0] evt = 3'h0;
    logic [1:0] mode = 2'h0;
    logic [PSCG_NPER-1:0] touch = '0, periph_access, periph_clk_en, periph_ready, periph_fault;
    logic [3:0] regulator_level;
    int err_count = 0, total_checks = 0, n;
    always #50 clock = ~clock;
    pscg_core_model core (.clock(clock), .rst(rst), .mode(mode), .touch(touch), .proc_sleep(proc_sleep),
        .proc_deep_sleep(proc_deep_sleep), .periph_access(periph_access));
    pscg_top dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .main_osc_powerup_event(evt[0]), .freq_synth_locked_event(evt[1]), .brownout_event(evt[2]),
        .proc_sleep(proc_sleep), .proc_deep_sleep(proc_deep_sleep), .periph_access(periph_access),
        .periph_clk_en(periph_clk_en), .periph_ready(periph_ready), .periph_fault(periph_fault),
        .regulator_level(regulator_level), .irq(irq));
    task close_out;
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        // Ack and read data are taken at the rising edge, then the request drops
        do begin @(posedge clock); k++; end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            close_out();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_io
    // Model register, two sync stages and clock enable register need four edges
    task go(input logic [1:0] m);
        @(posedge clock);
        mode <= m;
        repeat (5) @(posedge clock);
        @(negedge clock);
    endtask : go
    task t_level;
        wb_io(0, PSCG_LEVEL_OFS, 0); chk(q, {28'h0, PSCG_LEVEL_DEFAULT});
        wb_io(0, PSCG_RUN_OFS, 0); chk(q, 0);
        wb_io(1, PSCG_LEVEL_OFS, 32'h0000_000a); wb_io(0, PSCG_LEVEL_OFS, 0); chk(q, 32'h0000_000a);
        wb_io(1, PSCG_LEVEL_OFS, 32'h0000_000b); wb_io(0, PSCG_LEVEL_OFS, 0); chk(q, 32'h0000_000a);
        @(negedge clock); chk(regulator_level, 4'ha);
        wb_io(1, PSCG_LEVEL_OFS, 0); wb_io(0, PSCG_LEVEL_OFS, 0); chk(q, 0);
        wb_io(0, 8'h3c, 0); chk(q, 0);
    endtask : t_level
    task t_events;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock); evt <= 3'b001 << i;
            repeat (2) @(posedge clock); evt <= 3'h0;
            repeat (3) @(posedge clock);
            wb_io(0, PSCG_RAW_OFS, 0); chk(q, 32'h1 << i);
            @(negedge clock); chk(irq, 0);
            wb_io(1, PSCG_CTRL_OFS, 32'h0000_0002); wb_io(0, PSCG_STAT_OFS, 0); chk(q, 0);
            wb_io(1, PSCG_MASK_OFS, 32'h1 << i); wb_io(0, PSCG_STAT_OFS, 0); chk(q, 32'h1 << i);
            @(negedge clock); chk(irq, 1);
            wb_io(1, PSCG_CLR_OFS, 32'h1 << i); @(negedge clock); chk(irq, 0);
            wb_io(0, PSCG_RAW_OFS, 0); chk(q, 0);
            wb_io(1, PSCG_MASK_OFS, 0); wb_io(1, PSCG_CTRL_OFS, 0);
        end
    endtask : t_events
    task t_enable;
        @(posedge clock); touch <= 26'h000_0001;
        wb_io(1, PSCG_SLEEP_OFS, 32'hffff_ffff); wb_io(0, PSCG_SLEEP_OFS, 0); chk(q, 32'h03ff_ffff);
        wb_io(1, PSCG_RUN_OFS, 32'h0000_0003);
        @(negedge clock); chk(periph_fault[0], 1);
        n = 1;
        while (periph_ready[0] !== 1'b1 && n < 10) begin @(negedge clock); n++; end
        chk(n, 5);
        chk(periph_fault[0], 0);
        chk(periph_clk_en[1:0], 2'b11);
        chk(periph_clk_en[2], 0);
        wb_io(0, PSCG_READY_OFS, 0); chk(q, 32'h0000_0003);
    endtask : t_enable
    task t_gating;
        wb_io(1, PSCG_DEEP_OFS, 32'h0000_0001);
        wb_io(1, PSCG_SLEEP_OFS, 32'h0000_0002);
        go(2'h2); chk(periph_clk_en[1:0], 2'b11);
        go(2'h1); chk(periph_clk_en[1:0], 2'b11);
        wb_io(1, PSCG_CTRL_OFS, 32'h0000_0001);
        go(2'h1); chk(periph_clk_en[1:0], 2'b10);
        go(2'h2); chk(periph_clk_en[1:0], 2'b01);
        go(2'h0); chk(periph_clk_en[1:0], 2'b11);
        wb_io(0, PSCG_DEEP_OFS, 0); chk(q, 32'h0000_0001);
        wb_io(0, PSCG_READY_OFS, 0); chk(q, 32'h0000_0003);
    endtask : t_gating
    // Mid-run reset must bring back the power-up state
    task t_reset;
        wb_io(1, PSCG_LEVEL_OFS, 32'h0000_0003);
        wb_io(1, PSCG_CTRL_OFS, 32'h0000_0003);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(negedge clock);
        chk(regulator_level, PSCG_LEVEL_DEFAULT);
        chk(periph_ready, 0);
        chk(periph_clk_en, 0);
        chk(periph_fault[0], 1);
        wb_io(0, PSCG_RUN_OFS, 0); chk(q, 0);
        wb_io(0, PSCG_CTRL_OFS, 0); chk(q, 0);
        wb_io(0, PSCG_LEVEL_OFS, 0); chk(q, {28'h0, PSCG_LEVEL_DEFAULT});
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_level();
        t_events();
        t_enable();
        t_gating();
        t_reset();
        close_out();
    end
endmodule : tb
bind pscg_top pscg_props u_props (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .proc_sleep(proc_sleep), .proc_deep_sleep(proc_deep_sleep),
    .periph_access(periph_access), .periph_clk_en(periph_clk_en), .periph_ready(periph_ready),
    .periph_fault(periph_fault), .regulator_level(regulator_level), .irq(irq));
